// ==== bench/lcdsrl_master_model.sv ====
// lcdsrl_master_model: behavioural two-wire bus master for the bench.
// assumes: bench resolves SDA with a pull-up; timing from SYS_CLK.
`timescale 1ns/1ps

module lcdsrl_master_model (
  input wire logic clk,  // system clock
  input wire logic sda,  // resolved SDA level
  output logic scl,      // bus clock
  output logic sda_low   // pull SDA low
);
  int half_clks = 5; // clocks per SCL half period, never under 4

  // ---------------------------------------------------------------
  // bus primitives, all changes land on falling clock edges
  // ---------------------------------------------------------------
  initial begin
    scl = 1'h1;
    sda_low = 1'h0;
  end

  // one SCL half period
  task automatic half_wait();
    repeat (half_clks) @(negedge clk);
  endtask : half_wait

  // start or repeated start: SDA falls while SCL is high
  task automatic bus_start();
    @(negedge clk);
    sda_low = 1'h0;
    half_wait();
    scl = 1'h1;
    half_wait();
    sda_low = 1'h1;
    half_wait();
    scl = 1'h0;
  endtask : bus_start

  // stop: SDA rises while SCL is high, bus left idle
  task automatic bus_stop();
    @(negedge clk);
    sda_low = 1'h1;
    half_wait();
    scl = 1'h1;
    half_wait();
    sda_low = 1'h0;
    half_wait();
  endtask : bus_stop

  // eight bits msb first, then sample the slave's acknowledge
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      @(negedge clk);
      sda_low = ~b[i];
      half_wait();
      scl = 1'h1;
      half_wait();
      scl = 1'h0;
    end
    @(negedge clk);
    sda_low = 1'h0;
    half_wait();
    scl = 1'h1;
    ack = ~sda;
    half_wait();
    scl = 1'h0;
  endtask : send_byte
endmodule : lcdsrl_master_model

// ==== bench/lcdsrl_top_tb.sv ====
// lcdsrl_top_tb: self-checking bench of the segment register loader.
// assumes: lcdsrl_master_model drives the bus; straps set by the bench.
`timescale 1ns/1ps

module lcdsrl_top_tb;
  import lcdsrl_pkg::*;

  // ---------------------------------------------------------------
  // signals and bench state
  // ---------------------------------------------------------------
  logic sys_clk, rst_n, osc_rc, osc_pin, a1, a2_strap, bp1_drv, ack_seen;
  logic scl, sda_low, sda_o, sda_oe, bp2_o, bp2_oe, bp1_o, bp1_oe;
  logic cascade, tick;
  logic [BYTE_W-1:0] ctrl, exp_ctrl;
  logic [DISP_W-1:0] plane1, plane2;
  logic [BYTE_W-1:0] seg [SEG_REGS];
  logic [31:0] r;
  int fails, samples_checked;
  int seed = 32'h3CCE33AF;
  wire sda_w;
  wire bp2_w;
  wire bp1_w;

  // open-drain SDA with pull-up; straps and pull-down on shared pins
  assign sda_w = ~(sda_low | sda_oe);
  assign bp2_w = bp2_oe ? bp2_o : a2_strap;
  assign bp1_w = bp1_oe ? bp1_o : bp1_drv;

  lcdsrl_master_model i_master (.clk(sys_clk), .sda(sda_w), .scl(scl),
    .sda_low(sda_low));

  lcdsrl_top i_lcdsrl_top (.SYS_CLK(sys_clk), .RST_N(rst_n), .SCL(scl),
    .SDA_I(sda_w), .SDA_O(sda_o), .SDA_OE(sda_oe),
    .SUBADDR0_OSC_PIN(osc_pin), .OSC_RC_PRESENT(osc_rc),
    .SUBADDR_BIT1(a1), .SUBADDR2_BACKPLANE2_PIN_I(bp2_w),
    .SUBADDR2_BACKPLANE2_PIN_O(bp2_o), .SUBADDR2_BACKPLANE2_PIN_OE(bp2_oe),
    .BACKPLANE_ONE_I(bp1_w), .BACKPLANE_ONE_O(bp1_o),
    .BACKPLANE_ONE_OE(bp1_oe), .DISPLAY_PLANE_ONE(plane1),
    .DISPLAY_PLANE_TWO(plane2), .DISPLAY_CONTROL(ctrl),
    .CASCADE_MODE(cascade), .FRAME_TICK(tick));

  // ---------------------------------------------------------------
  // expectation functions and checking tasks
  // ---------------------------------------------------------------
  // strap subaddress as the device should read it
  function automatic logic [2:0] subaddr();
    return {a2_strap, a1, osc_rc ? 1'h0 : osc_pin};
  endfunction : subaddr

  // one bank gathered into a display plane, byte g from register 2g+odd
  function automatic logic [31:0] bank(input logic odd);
    logic [2:0] o;
    o = {2'h0, odd};
    return {seg[3'h6 | o], seg[3'h4 | o], seg[3'h2 | o], seg[o]};
  endfunction : bank

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  // addressed write: control byte then n data bytes, checked on the way
  task automatic xfer(input logic [7:0] c, input int n);
    logic [2:0] sa;
    logic [7:0] d;
    logic hit;
    logic [31:0] p1, p2;
    sa = subaddr();
    i_master.bus_start();
    i_master.send_byte({SLAVE_ADDR, 1'h0}, ack_seen);
    check("addr ack", ack_seen, 1'h1);
    i_master.send_byte(c, ack_seen);
    check("ctrl ack", ack_seen, 1'h1);
    exp_ctrl = c;
    for (int k = 0; k < n; k++) begin
      d = 8'($random(seed));
      hit = exp_ctrl[7] ? (exp_ctrl[4:3] == sa[1:0])
                        : (exp_ctrl[5:3] == sa);
      i_master.send_byte(d, ack_seen);
      check("data ack", ack_seen, hit);
      if (hit)
        seg[exp_ctrl[2:0]] = d;
      exp_ctrl[5:0] = exp_ctrl[5:0] + (exp_ctrl[7] ? 6'h01 : 6'h02);
    end
    i_master.bus_stop();
    repeat (3) @(negedge sys_clk);
    check("control", ctrl, exp_ctrl);
    p1 = exp_ctrl[7] ? bank(1'h0) : bank(exp_ctrl[6]);
    p2 = exp_ctrl[7] ? bank(1'h1) : 32'h0;
    check("plane one", plane1, p1);
    check("plane two", plane2, p2);
  endtask : xfer

  // ---------------------------------------------------------------
  // clock and main sequence
  // ---------------------------------------------------------------
  initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end

  initial begin
    rst_n = 1'h0;
    osc_rc = 1'h1;
    osc_pin = 1'h0;
    a1 = 1'h1;
    a2_strap = 1'h0;
    bp1_drv = 1'h0;
    fails = 0;
    samples_checked = 0;
    foreach (seg[i]) seg[i] = 8'h00;
    repeat (3) @(negedge sys_clk);
    rst_n = 1'h1;
    repeat (2) @(negedge sys_clk);
    check("reset ctrl", ctrl, 8'h00);
    check("reset planes", plane1 | plane2, 32'h0);
    // master mode: own divider ticks, backplanes in opposite phase
    for (int w = 0; w < 1100 && tick !== 1'h1; w++) @(negedge sys_clk);
    check("master tick", tick, 1'h1);
    @(negedge sys_clk);
    check("backplanes", {bp1_o, bp2_o}, 2'h2);
    check("sda out", sda_o, 1'h0);
    // direct: bank A full, bank B partial, then bank flip alone
    xfer(8'h10, 4);
    xfer(8'h51, 2);
    xfer(8'h10, 0);
    // slow master, loading runs from device 001 into device 010
    i_master.half_clks = 9;
    xfer(8'h0E, 3);
    i_master.half_clks = 4;
    // duplex with strap high: bit 5 of the vector must not matter
    a2_strap = 1'h1;
    xfer(8'hB0, 8);
    check("bp2 drive", bp2_oe, 1'h1);
    // refused: wrong address, then read bit set
    for (int j = 0; j < 2; j++) begin
      i_master.bus_start();
      i_master.send_byte({SLAVE_ADDR ^ 7'(j ^ 1), 1'(j)}, ack_seen);
      check("bad addr ack", ack_seen, 1'h0);
      i_master.send_byte(8'hC0, ack_seen);
      i_master.bus_stop();
      check("ctrl kept", ctrl, exp_ctrl);
    end
    // random controls aimed near this device, both modes
    repeat (6) begin
      r = $random(seed);
      xfer({r[7:6], 3'h6, r[2:0]}, int'(r[10:8]));
    end
    // cascade: pin tied high reads subaddress bit 0 as one
    osc_rc = 1'h0;
    osc_pin = 1'h1;
    a2_strap = 1'h0;
    repeat (2) @(negedge sys_clk);
    check("cascade", {cascade, bp1_oe}, 2'h2);
    bp1_drv = 1'h1;
    for (int w = 0; w < 4 && tick !== 1'h1; w++) @(negedge sys_clk);
    check("sync tick", tick, 1'h1);
    xfer(8'h16, 2);
    // reset in mid-run clears everything again
    rst_n = 1'h0;
    @(negedge sys_clk);
    check("rerun ctrl", ctrl, 8'h00);
    check("rerun planes", plane1 | plane2, 32'h0);
    check("rerun drive", {bp1_oe, bp2_oe, sda_oe}, 3'h0);
    rst_n = 1'h1;
    print_verdict();
  end
endmodule : lcdsrl_top_tb

// ==== logic/lcdsrl_bus_if.sv ====
// lcdsrl_bus_if: byte events between the bus receiver and the register core.
// assumes: both ends on SYS_CLK; pulses last one cycle.
`timescale 1ns/1ps

interface lcdsrl_bus_if;
  logic start;       // start or repeated start seen
  logic stop;        // stop seen
  logic byte_stb;    // one byte received
  logic [7:0] byte_data;
  logic ack_ok;      // core wants this byte acknowledged

  modport rx (output start, stop, byte_stb, byte_data, input ack_ok);
  modport core (input start, stop, byte_stb, byte_data, output ack_ok);
endinterface : lcdsrl_bus_if

// ==== logic/lcdsrl_byte_rx.sv ====
// lcdsrl_byte_rx: receive-only two-wire bus bit engine with acknowledge.
// assumes: SCL and SDA are sampled as synchronous inputs, far slower
// than SYS_CLK, so the core answers ack_ok long before the next SCL fall.
`timescale 1ns/1ps

module lcdsrl_byte_rx (
  input wire logic clk,        // system clock
  input wire logic rst_n,      // async reset, active low
  input wire logic scl,        // bus clock level
  input wire logic sda,        // bus data level
  output logic sda_oe,         // pull SDA low
  lcdsrl_bus_if.rx bus         // byte events
);
  import lcdsrl_pkg::*;

  logic scl_q, sda_q;
  logic [3:0] bitcnt_q;
  logic [6:0] shift_q;
  logic stb_q, start_q, stop_q, ack_pend_q, oe_q;
  logic [7:0] data_q;

  // ----------------------------------------------------------------
  // edge and condition decode
  // ----------------------------------------------------------------
  wire scl_rise = scl & ~scl_q;
  wire scl_fall = ~scl & scl_q;
  wire start_c = scl & scl_q & sda_q & ~sda;
  wire stop_c = scl & scl_q & ~sda_q & sda;

  // previous pin levels
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end

  // bit counter and shifter; ninth rise is the acknowledge slot
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bitcnt_q <= 4'h0;
      shift_q <= 7'h00;
      data_q <= 8'h00;
    end else if (start_c || stop_c) begin
      bitcnt_q <= 4'h0;
    end else if (scl_rise) begin
      bitcnt_q <= (bitcnt_q == BIT_ACK) ? 4'h0 : bitcnt_q + 4'h1;
      shift_q <= {shift_q[5:0], sda};
      if (bitcnt_q == BIT_LAST) data_q <= {shift_q, sda};
    end
  end

  // one-cycle event pulses
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stb_q <= 1'b0;
      start_q <= 1'b0;
      stop_q <= 1'b0;
    end else begin
      stb_q <= scl_rise && !start_c && !stop_c && (bitcnt_q == BIT_LAST);
      start_q <= start_c;
      stop_q <= stop_c;
    end
  end

  // acknowledge: pull low from the fall after bit 8 to the next fall
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_pend_q <= 1'b0;
      oe_q <= 1'b0;
    end else if (start_c || stop_c) begin
      ack_pend_q <= 1'b0;
      oe_q <= 1'b0;
    end else if (stb_q) begin
      ack_pend_q <= bus.ack_ok;
    end else if (scl_fall) begin
      oe_q <= ack_pend_q;
      ack_pend_q <= 1'b0;
    end
  end

  assign bus.start = start_q;
  assign bus.stop = stop_q;
  assign bus.byte_stb = stb_q;
  assign bus.byte_data = data_q;
  assign sda_oe = oe_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_ack_on_fall: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(oe_q) |-> $past(scl_fall) && $past(ack_pend_q))
    else $error("acknowledge drive began away from an SCL fall");

endmodule : lcdsrl_byte_rx

// ==== logic/lcdsrl_pkg.sv ====
// lcdsrl_pkg: constants, field layout and state type of the LCD segment
// register loader.
// assumes: one 100 MHz clock, a two-wire bus whose pins are synchronous.
//
// Behaviour
// - subaddress bit 0 reads 0 with RC oscillator or pin low, 1 when high.
// - direct mode: shared pin is subaddress bit 2 only, pull-down gives 0.
// - duplex mode: shared pin drives backplane two except in cascade, select uses bits 1 and 0.
// - oscillator pin on a rail selects cascade, timing taken from backplanes.
// - nine writable bytes: one control register and eight segment bytes.
// - even segment bytes form bank A, odd segment bytes form bank B.
// - every addressed device stores the second byte as its control byte.
// - vector bits 5..3 against subaddress; mismatch ignores data, stays active.
// - vector bits 2..0 pick the segment byte that takes the next byte.
// - drive-mode bit 0 means direct drive, 1 means duplex drive.
// - direct mode shows even bank on bank bit 0, odd bank on 1.
// - vector increments after every loaded segment byte.
// - increment carries into device-select bits, loading crosses devices.
// - direct mode increments the vector by two, staying in one bank.
// - either bank loads fully or partly whatever bank is shown.
// - duplex mode increments the vector by one.
// - reset clears all segment bytes and the control register.
// - stop right after control byte leaves segment bytes unchanged.
// - during data only the matching device acknowledges each byte.

package lcdsrl_pkg;

  localparam int BYTE_W = 8;
  localparam int SEG_REGS = 8;
  localparam int BANK_BYTES = 4;
  localparam int DISP_W = 32;
  localparam int SBV_W = 6;
  // control register fields
  localparam int CTRL_MODE_BIT = 7;
  localparam int CTRL_BANK_BIT = 6;
  localparam int SBV_DEV_HI = 5;
  localparam int SBV_DEV_LO = 3;
  localparam int SBV_REG_HI = 2;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] SEG_RESET = 8'h00;
  // vector steps per mode
  localparam logic [5:0] INC_DIRECT = 6'h02;
  localparam logic [5:0] INC_DUPLEX = 6'h01;
  // seven-bit bus address; value is an arbitrary default
  localparam logic [6:0] SLAVE_ADDR = 7'h3A;
  // bit counter marks
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  // master-mode frame divider, cycles per frame tick
  localparam logic [15:0] FRAME_DIV = 16'h03E8;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_CTRL,
    ST_DATA,
    ST_SKIP
  } lcdsrl_state_e;

endpackage : lcdsrl_pkg

// ==== logic/lcdsrl_top.sv ====
// lcdsrl_top: control register, segment byte storage, device select and
// frame timing of a direct/duplex LCD segment driver loaded over the
// two-wire bus.
// assumes: pins synchronous to SYS_CLK; the pull-down on the shared
// subaddress-2 pin and the open-drain wires are resolved outside.
`timescale 1ns/1ps

module lcdsrl_top (
  input wire logic SYS_CLK,                      // 100 MHz clock
  input wire logic RST_N,                        // async reset, low
  input wire logic SCL,                          // bus clock
  input wire logic SDA_I,                        // bus data in
  output logic SDA_O,                            // bus data out, always 0
  output logic SDA_OE,                           // pull SDA low
  input wire logic SUBADDR0_OSC_PIN,             // shared pin level
  input wire logic OSC_RC_PRESENT,               // RC network on pin
  input wire logic SUBADDR_BIT1,                 // subaddress bit 1
  input wire logic SUBADDR2_BACKPLANE2_PIN_I,    // shared pin in
  output logic SUBADDR2_BACKPLANE2_PIN_O,        // backplane two out
  output logic SUBADDR2_BACKPLANE2_PIN_OE,       // backplane two drive
  input wire logic BACKPLANE_ONE_I,              // backplane one in
  output logic BACKPLANE_ONE_O,                  // backplane one out
  output logic BACKPLANE_ONE_OE,                 // backplane one drive
  output logic [lcdsrl_pkg::DISP_W-1:0] DISPLAY_PLANE_ONE, // bp1 data
  output logic [lcdsrl_pkg::DISP_W-1:0] DISPLAY_PLANE_TWO, // bp2 data
  output logic [lcdsrl_pkg::BYTE_W-1:0] DISPLAY_CONTROL,   // control
  output logic CASCADE_MODE,                     // timing from backplanes
  output logic FRAME_TICK                        // frame timing pulse
);
  import lcdsrl_pkg::*;

  lcdsrl_bus_if u_bus ();

  lcdsrl_state_e state_q, state_d;
  logic [7:0] ctrl_q, ctrl_d;
  logic [7:0] seg_q [0:SEG_REGS-1];
  logic [15:0] div_q;
  logic phase_q, bp1_q, tick_q, cascade_q, sda_o_q;
  logic bp1_o_q, bp1_oe_q, bp2_o_q, bp2_oe_q;
  logic [DISP_W-1:0] disp_one_q, disp_two_q;
  logic [2:0] chk_idx_q;

  // ----------------------------------------------------------------
  // bus receiver
  // ----------------------------------------------------------------
  lcdsrl_byte_rx u_rx (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .scl(SCL),
    .sda(SDA_I),
    .sda_oe(SDA_OE),
    .bus(u_bus.rx)
  );

  // step of the vector for the present mode
  function automatic logic [5:0] sbv_step(input logic duplex);
    sbv_step = duplex ? INC_DUPLEX : INC_DIRECT;
  endfunction : sbv_step

  // ----------------------------------------------------------------
  // control fields and subaddress
  // ----------------------------------------------------------------
  wire mode_duplex = ctrl_q[CTRL_MODE_BIT];
  wire bank_sel = ctrl_q[CTRL_BANK_BIT];
  wire [5:0] segment_byte_vector = ctrl_q[SBV_W-1:0];
  wire [2:0] dev_sel = segment_byte_vector[SBV_DEV_HI:SBV_DEV_LO];
  wire [2:0] reg_sel = segment_byte_vector[SBV_REG_HI:0];
  // RC network holds the pin at oscillator levels: reads as 0
  wire subaddr_bit0 = OSC_RC_PRESENT ? 1'b0 : SUBADDR0_OSC_PIN;
  wire subaddr_bit1 = SUBADDR_BIT1;
  // shared pin is an address input only in direct mode
  wire subaddr_bit2 = mode_duplex ? 1'b0 : SUBADDR2_BACKPLANE2_PIN_I;
  wire cascade = ~OSC_RC_PRESENT;

  // device select: duplex ignores the undefined bit 2
  wire sel_direct = dev_sel == {subaddr_bit2, subaddr_bit1, subaddr_bit0};
  wire sel_duplex = dev_sel[1:0] == {subaddr_bit1, subaddr_bit0};
  wire sel_match = mode_duplex ? sel_duplex : sel_direct;

  // ----------------------------------------------------------------
  // byte handling decode
  // ----------------------------------------------------------------
  wire stb = u_bus.byte_stb;
  wire [7:0] rx_byte = u_bus.byte_data;
  wire addr_hit = (rx_byte[7:1] == SLAVE_ADDR) && !rx_byte[0];
  wire in_addr = state_q == ST_ADDR;
  wire in_ctrl = state_q == ST_CTRL;
  wire in_data = state_q == ST_DATA;
  // all addressed devices take the control byte
  wire ctrl_load = stb && in_ctrl;
  // every device steps the vector so copies stay identical
  wire sbv_adv = stb && in_data;
  // only the selected device stores, bank is never checked
  wire seg_wr = sbv_adv && sel_match;
  wire [5:0] sbv_next = segment_byte_vector + sbv_step(mode_duplex);

  // acknowledge decision for the byte now on the interface
  assign u_bus.ack_ok = (in_addr && addr_hit) || in_ctrl ||
                        (in_data && sel_match);

  // next control value
  always_comb begin
    ctrl_d = ctrl_q;
    if (ctrl_load) begin
      ctrl_d = rx_byte;
    end else if (sbv_adv) begin
      ctrl_d = {ctrl_q[7:6], sbv_next};
    end
  end

  // transfer sequence: address, control byte, data bytes
  always_comb begin
    state_d = state_q;
    if (u_bus.start) begin
      state_d = ST_ADDR;
    end else if (u_bus.stop) begin
      state_d = ST_IDLE;
    end else if (stb) begin
      case (state_q)
        ST_ADDR: state_d = addr_hit ? ST_CTRL : ST_SKIP;
        ST_CTRL: state_d = ST_DATA;
        ST_DATA: state_d = ST_DATA;
        ST_SKIP: state_d = ST_SKIP;
        ST_IDLE: state_d = ST_IDLE;
        default: state_d = ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // state and control register, cleared at power-on
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= ST_IDLE;
      ctrl_q <= CTRL_RESET;
    end else begin
      state_q <= state_d;
      ctrl_q <= ctrl_d;
    end
  end

  // eight segment bytes, even bank A, odd bank B
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < SEG_REGS; i++) begin
        seg_q[i] <= SEG_RESET;
      end
    end else if (seg_wr) begin
      seg_q[reg_sel] <= rx_byte;
    end
  end

  // index of the last written byte, read by checks only
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      chk_idx_q <= 3'h0;
    end else if (seg_wr) begin
      chk_idx_q <= reg_sel;
    end
  end

  // ----------------------------------------------------------------
  // frame timing: own divider, or backplane one in cascade
  // ----------------------------------------------------------------
  wire bp1_rise = BACKPLANE_ONE_I & ~bp1_q;
  wire div_done = div_q == (FRAME_DIV - 16'h0001);
  wire tick = cascade ? bp1_rise : div_done;

  // divider, edge history and frame phase
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      div_q <= 16'h0000;
      bp1_q <= 1'b0;
      tick_q <= 1'b0;
      phase_q <= 1'b0;
      cascade_q <= 1'b0;
    end else begin
      div_q <= (div_done || cascade) ? 16'h0000 : div_q + 16'h0001;
      bp1_q <= BACKPLANE_ONE_I;
      tick_q <= tick;
      cascade_q <= cascade;
      if (tick) phase_q <= ~phase_q;
    end
  end

  // backplane pins: one driven in master mode, two only in master duplex; both released in cascade
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      bp1_o_q <= 1'b0;
      bp1_oe_q <= 1'b0;
      bp2_o_q <= 1'b0;
      bp2_oe_q <= 1'b0;
      sda_o_q <= 1'b0;
    end else begin
      bp1_o_q <= phase_q;
      bp1_oe_q <= ~cascade;
      bp2_o_q <= ~phase_q;
      bp2_oe_q <= mode_duplex & ~cascade;
      sda_o_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // display data per backplane
  // ----------------------------------------------------------------
  logic [DISP_W-1:0] disp_one_d, disp_two_d;
  for (genvar g = 0; g < BANK_BYTES; g++) begin : g_disp
    wire [7:0] even_b = seg_q[2*g];
    wire [7:0] odd_b = seg_q[2*g+1];
    // direct: chosen bank on plane one; duplex: even one, odd two
    assign disp_one_d[BYTE_W*g +: BYTE_W] =
      (!mode_duplex && bank_sel) ? odd_b : even_b;
    assign disp_two_d[BYTE_W*g +: BYTE_W] = mode_duplex ? odd_b : 8'h00;
  end

  // registered display and status outputs
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      disp_one_q <= '0;
      disp_two_q <= '0;
    end else begin
      disp_one_q <= disp_one_d;
      disp_two_q <= disp_two_d;
    end
  end

  assign DISPLAY_PLANE_ONE = disp_one_q;
  assign DISPLAY_PLANE_TWO = disp_two_q;
  assign DISPLAY_CONTROL = ctrl_q;
  assign CASCADE_MODE = cascade_q;
  assign FRAME_TICK = tick_q;
  assign BACKPLANE_ONE_O = bp1_o_q;
  assign BACKPLANE_ONE_OE = bp1_oe_q;
  assign SUBADDR2_BACKPLANE2_PIN_O = bp2_o_q;
  assign SUBADDR2_BACKPLANE2_PIN_OE = bp2_oe_q;
  assign SDA_O = sda_o_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  wire [63:0] seg_all = {seg_q[7], seg_q[6], seg_q[5], seg_q[4],
                         seg_q[3], seg_q[2], seg_q[1], seg_q[0]};

  sequence s_ctrl_byte;
    stb && in_ctrl;
  endsequence

  sequence s_data_byte;
    stb && in_data && !u_bus.start && !u_bus.stop;
  endsequence

  a_ctrl_load: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    s_ctrl_byte ##1 1'b1 |-> ctrl_q == $past(rx_byte))
    else $error("control byte not stored");

  a_seg_write: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    seg_wr |=> seg_q[chk_idx_q] == $past(rx_byte))
    else $error("segment byte not stored at vector index");

  a_inc_direct: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    s_data_byte and !mode_duplex |=>
      segment_byte_vector == 6'($past(segment_byte_vector) + 6'h02))
    else $error("direct mode vector did not step by two");

  a_inc_duplex: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    s_data_byte and mode_duplex |=>
      segment_byte_vector == 6'($past(segment_byte_vector) + 6'h01))
    else $error("duplex mode vector did not step by one");

  a_skip_keep: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    s_data_byte and !sel_match |=>
      $stable(seg_all) && !$past(u_bus.ack_ok))
    else $error("unselected device changed segment data");

  a_stop_keep: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    in_data && u_bus.stop |=>
      $stable(seg_all) && state_q == ST_IDLE)
    else $error("stop after control byte altered segments");

  a_duplex_sel: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    in_data && mode_duplex |-> u_bus.ack_ok ==
      (ctrl_q[4:3] == {SUBADDR_BIT1, subaddr_bit0}))
    else $error("duplex select depends on bit 2");

  a_bank_view: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    !mode_duplex |=> disp_one_q[7:0] == ($past(bank_sel) ?
      $past(seg_q[1]) : $past(seg_q[0])))
    else $error("direct mode shows wrong bank");

  a_bp2_input: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    !mode_duplex ##1 !mode_duplex |-> !bp2_oe_q)
    else $error("shared pin driven in direct mode");

  a_cascade_sync: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    cascade && bp1_rise |=> FRAME_TICK ##1 !FRAME_TICK[*1])
    else $error("cascade frame not taken from backplane");

endmodule : lcdsrl_top
